// ===== inc/sacr_pkg.sv
// constants and types for the per-port clock recovery front end
package sacr_pkg;
  // ****************************************************************
  // clock and widths
  // ****************************************************************
  localparam longint CLK_HZ = 250_000_000;
  localparam int TS_W = 5;
  localparam int NIB_W = 4;
  localparam int ERR_BIT = 4;
  localparam int FDEPTH = 4;
  localparam int PTR_W = 2;
  localparam int PW_W = 8;
  localparam int OFS_W = 16;
  localparam int ADDR_W = 8;
  localparam int NDIV_W = 10;
  localparam int ST_W = 4;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] A_AVG = 8'h0c;
  localparam logic [ADDR_W-1:0] A_CPU_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] A_FILTER = 8'h14;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int FILTER_HOLD_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // status / mask bit positions
  localparam int ST_OVF = 0;
  localparam int ST_UDR = 1;
  localparam int ST_ERR = 2;
  localparam int ST_SLIP = 3;

  // ****************************************************************
  // modes
  // ****************************************************************
  typedef enum logic [1:0] {SRC_LINE, SRC_TS, SRC_NET, SRC_ADAPT} sacr_src_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_HOLD, MODE_FREE, MODE_CPU} sacr_mode_t;
  localparam logic [1:0] RATE_1544 = 2'h0;
  localparam logic [1:0] RATE_2048 = 2'h1;
  localparam logic [1:0] RATE_4096 = 2'h2;

  // reset values
  localparam logic [1:0] RATE_RST = RATE_2048;
  localparam logic [PW_W-1:0] AVG_RST = 8'h80;

  // dco increments: f * 2^32 / clk
  localparam logic [31:0] INC_1544 = 32'((64'd1544000 << 32) / 64'(CLK_HZ));
  localparam logic [31:0] INC_2048 = 32'((64'd2048000 << 32) / 64'(CLK_HZ));
  localparam logic [31:0] INC_4096 = 32'((64'd4096000 << 32) / 64'(CLK_HZ));
  // output edges per 8 kHz network reference edge
  localparam logic [NDIV_W-1:0] NDIV_1544 = 10'h0c1;
  localparam logic [NDIV_W-1:0] NDIV_2048 = 10'h100;
  localparam logic [NDIV_W-1:0] NDIV_4096 = 10'h200;

  // ****************************************************************
  // adaptive phaseword codes and loop limits
  // ****************************************************************
  localparam logic [PW_W-1:0] PW_SLIP_UNDER = 8'h00;
  localparam logic [PW_W-1:0] PW_SLIP_OVER = 8'hff;
  localparam logic [PW_W-1:0] PW_NO_ADJUST = 8'h7f;
  localparam logic signed [OFS_W-1:0] SLIP_STEP = 16'sh0040;
  localparam logic signed [OFS_W-1:0] OFS_LIM = 16'sh3e80;

  typedef struct packed {
    logic [FDEPTH-1:0][TS_W-1:0] fifo;
    logic [FDEPTH-1:0] fval;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic hold_auto;
    logic [1:0] line_s;
    logic line_d;
    logic [1:0] net_s;
    logic net_d;
    logic [NDIV_W-1:0] net_cnt;
    logic signed [OFS_W-1:0] integ;
    logic [31:0] acc;
    logic clk_out;
    logic [1:0] rate;
    sacr_src_t src;
    sacr_mode_t mode;
    logic [PW_W-1:0] avg;
    logic signed [OFS_W-1:0] cpu_ofs;
    logic [ST_W-1:0] sts;
    logic [ST_W-1:0] msk;
    logic irq;
    logic hold_out;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sacr_state_t;
endpackage : sacr_pkg

// ===== design/sacr_top.sv
// per-port time-stamp fifo, adaptive phaseword path and digital pll
`timescale 1ns/10ps
`default_nettype none
module sacr_top import sacr_pkg::*; (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ts_valid,
  input wire logic [TS_W-1:0] i_ts_data,
  input wire logic i_local_ts_valid,
  input wire logic [NIB_W-1:0] i_local_ts,
  input wire logic i_phase_valid,
  input wire logic [PW_W-1:0] i_phase_word,
  input wire logic i_line_clk,
  input wire logic i_net_clk,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_recovered_port_clock,
  output logic o_holdover,
  output logic o_irq
);
  // one instance per port: nothing here is shared between ports
  sacr_state_t r;
  sacr_state_t next_r;
  logic rd;
  logic line_edge;
  logic net_edge;
  logic dco_edge;
  logic [31:0] nom_inc;
  logic [NDIV_W-1:0] net_div;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic signed [OFS_W-1:0] clamp(input logic signed [OFS_W:0] v);
    if (v > 17'(OFS_LIM)) begin
      return OFS_LIM;
    end else if (v < -17'(OFS_LIM)) begin
      return -OFS_LIM;
    end
    return v[OFS_W-1:0];
  endfunction : clamp

  // ****************************************************************
  // rate and detector taps
  // ****************************************************************
  always_comb begin
    unique case (r.rate)
      RATE_1544: begin
        nom_inc = INC_1544;
        net_div = NDIV_1544;
      end
      RATE_4096: begin
        nom_inc = INC_4096;
        net_div = NDIV_4096;
      end
      default: begin
        nom_inc = INC_2048;
        net_div = NDIV_2048;
      end
    endcase
  end

  // second stage only; first sync stage feeds nothing else
  assign line_edge = r.line_s[1] & ~r.line_d;
  assign net_edge = r.net_s[1] & ~r.net_d;
  assign dco_edge = r.acc[31] & ~r.clk_out;
  // pll asks for a stamp each time the local reference stamp appears while SRC_TS is selected
  assign rd = i_local_ts_valid && (r.src == SRC_TS);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic signed [OFS_W-1:0] step;
    logic signed [OFS_W-1:0] ofs;
    logic [ST_W-1:0] set;
    logic [ST_W-1:0] clr;
    logic signed [NIB_W-1:0] dts;
    logic signed [PW_W:0] dpw;
    logic [31:0] wv;
    step = '0;
    ofs = '0;
    set = '0;
    clr = '0;
    dts = '0;
    dpw = '0;
    wv = '0;
    next_r = r;
    next_r.line_s = {r.line_s[0], i_line_clk};
    next_r.line_d = r.line_s[1];
    next_r.net_s = {r.net_s[0], i_net_clk};
    next_r.net_d = r.net_s[1];

    // fifo pop: always advances, even when empty
    if (rd) begin
      next_r.fval[r.rp] = 1'b0;
      next_r.rp = r.rp + 1'b1;
      if (!r.fval[r.rp]) begin
        set[ST_UDR] = 1'b1;
        next_r.hold_auto = 1'b1;
      end else if (r.fifo[r.rp][ERR_BIT]) begin
        // drop this pair so one lost cell does not kick the loop
        set[ST_ERR] = 1'b1;
      end else begin
        next_r.hold_auto = 1'b0;
        dts = NIB_W'(r.fifo[r.rp][NIB_W-1:0] - i_local_ts);
        step = OFS_W'(dts);
      end
    end
    // fifo push; a full slot drops the new stamp rather than the unread one
    if (i_ts_valid) begin
      if (r.fval[r.wp]) begin
        set[ST_OVF] = 1'b1;
      end else begin
        next_r.fifo[r.wp] = i_ts_data;
        next_r.fval[r.wp] = 1'b1;
        next_r.wp = r.wp + 1'b1;
      end
    end
    if (r.src != SRC_TS) begin
      next_r.hold_auto = 1'b0;
    end

    // phase detector per source
    unique case (r.src)
      SRC_LINE: begin
        step = OFS_W'(16'(line_edge) - 16'(dco_edge));
      end
      SRC_NET: begin
        step = net_edge ? 16'sh0001 : 16'sh0000;
        if (dco_edge) begin
          next_r.net_cnt = r.net_cnt + 1'b1;
          if (r.net_cnt >= net_div - 1'b1) begin
            next_r.net_cnt = '0;
            step = step - 16'sh0001;
          end
        end
      end
      SRC_ADAPT: begin
        if (i_phase_valid) begin
          if (i_phase_word == PW_SLIP_UNDER) begin
            set[ST_SLIP] = 1'b1;
            step = -SLIP_STEP;
          end else if (i_phase_word == PW_SLIP_OVER) begin
            set[ST_SLIP] = 1'b1;
            step = SLIP_STEP;
          end else if (i_phase_word != PW_NO_ADJUST) begin
            dpw = $signed({1'b0, i_phase_word}) - $signed({1'b0, r.avg});
            step = OFS_W'(dpw);
          end
        end
      end
      SRC_TS: begin
      end
    endcase

    // loop filter: integrator frozen in holdover
    if (r.mode == MODE_NORMAL && !r.hold_auto) begin
      next_r.integ = clamp(17'(r.integ) + 17'(step));
    end
    // dco and divide to the selected rate
    unique case (r.mode)
      MODE_FREE: ofs = '0;
      MODE_CPU: ofs = r.cpu_ofs;
      MODE_NORMAL, MODE_HOLD: ofs = r.integ;
    endcase
    next_r.acc = r.acc + nom_inc + 32'(ofs);
    next_r.clk_out = r.acc[31];
    next_r.hold_out = (r.mode == MODE_HOLD) || next_r.hold_auto;

    // ****************************************************************
    // axi4-lite slave
    // ****************************************************************
    if (i_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = i_awaddr;
    end
    if (i_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = i_wdata;
      next_r.wstrb = i_wstrb;
    end
    if (r.bvalid && i_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      unique case (r.awaddr)
        A_CTRL: begin
          wv = merge({26'h0, r.mode, r.src, r.rate}, r.wdata, r.wstrb);
          next_r.rate = wv[CTRL_RATE_LSB +: 2];
          next_r.src = sacr_src_t'(wv[CTRL_SRC_LSB +: 2]);
          next_r.mode = sacr_mode_t'(wv[CTRL_MODE_LSB +: 2]);
        end
        A_STATUS: begin
          if (r.wstrb[0]) begin
            clr = r.wdata[ST_W-1:0];
          end
        end
        A_MASK: begin
          wv = merge({28'h0, r.msk}, r.wdata, r.wstrb);
          next_r.msk = wv[ST_W-1:0];
        end
        A_AVG: begin
          wv = merge({24'h0, r.avg}, r.wdata, r.wstrb);
          next_r.avg = wv[PW_W-1:0];
        end
        A_CPU_OFS: begin
          wv = merge({16'h0, r.cpu_ofs}, r.wdata, r.wstrb);
          next_r.cpu_ofs = wv[OFS_W-1:0];
        end
        A_FILTER: begin
        end
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_r.sts = (r.sts & ~clr) | set;
    next_r.irq = |(next_r.sts & next_r.msk);

    if (r.rvalid && i_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (i_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = '0;
      unique case (i_araddr)
        A_CTRL: next_r.rdata = {26'h0, r.mode, r.src, r.rate};
        A_STATUS: next_r.rdata = {28'h0, r.sts};
        A_MASK: next_r.rdata = {28'h0, r.msk};
        A_AVG: next_r.rdata = {24'h0, r.avg};
        A_CPU_OFS: next_r.rdata = {16'h0, r.cpu_ofs};
        A_FILTER: next_r.rdata = {15'h0, r.hold_out, r.integ};
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r <= '0;
      r.rate <= RATE_RST;
      r.avg <= AVG_RST;
      r.src <= SRC_LINE;
      r.mode <= MODE_NORMAL;
    end else begin
      r <= next_r;
    end
  end

  assign o_awready = r.awready;
  assign o_wready = r.wready;
  assign o_bvalid = r.bvalid;
  assign o_bresp = r.bresp;
  assign o_arready = r.arready;
  assign o_rvalid = r.rvalid;
  assign o_rdata = r.rdata;
  assign o_rresp = r.rresp;
  assign o_recovered_port_clock = r.clk_out;
  assign o_holdover = r.hold_out;
  assign o_irq = r.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_good_read;
    rd && r.fval[r.rp] && !r.fifo[r.rp][ERR_BIT];
  endsequence
  sequence s_flag_read;
    rd && r.fval[r.rp] && r.fifo[r.rp][ERR_BIT];
  endsequence
  sequence s_adapt_word;
    r.src == SRC_ADAPT && r.mode == MODE_NORMAL && !r.hold_auto && i_phase_valid;
  endsequence

  // a push into the empty slot being popped legally refills it
  read_invalidate_a: assert property (rd && !(i_ts_valid && r.wp == r.rp)
    |=> !r.fval[$past(r.rp)] && r.rp == $past(r.rp) + 1'b1)
    else $error("read entry not invalidated");
  underrun_hold_a: assert property (rd && !r.fval[r.rp] |=> r.hold_auto && r.sts[ST_UDR])
    else $error("underrun did not force holdover");
  resume_read_a: assert property (s_good_read |=> !r.hold_auto)
    else $error("valid stamp did not leave holdover");
  flag_discard_a: assert property (s_flag_read |=> $stable(r.integ) && r.sts[ST_ERR])
    else $error("flagged stamp reached the loop");
  overflow_flag_a: assert property (i_ts_valid && r.fval[r.wp]
    |=> r.sts[ST_OVF] ##1 r.sts[ST_OVF])
    else $error("overflow not recorded");
  adapt_up_a: assert property (s_adapt_word ##0 (i_phase_word > r.avg
    && i_phase_word != PW_SLIP_OVER && i_phase_word != PW_NO_ADJUST
    && r.integ < 16'sh0100) |=> r.integ > $past(r.integ))
    else $error("fill above average did not speed clock");
  adapt_down_a: assert property (s_adapt_word ##0 (i_phase_word < r.avg
    && i_phase_word != PW_SLIP_UNDER && i_phase_word != PW_NO_ADJUST
    && r.integ > -16'sh0100) |=> r.integ < $past(r.integ))
    else $error("fill below average did not slow clock");
  slip_under_a: assert property (s_adapt_word ##0 (i_phase_word == PW_SLIP_UNDER
    && r.integ > SLIP_STEP - OFS_LIM)
    |=> r.integ == $past(r.integ) - SLIP_STEP && r.sts[ST_SLIP])
    else $error("underrun slip did not slow clock");
  slip_over_a: assert property (s_adapt_word ##0 (i_phase_word == PW_SLIP_OVER
    && r.integ < OFS_LIM - SLIP_STEP)
    |=> r.integ == $past(r.integ) + SLIP_STEP && r.sts[ST_SLIP])
    else $error("overflow slip did not speed clock");
  no_adjust_a: assert property (r.src == SRC_ADAPT && i_phase_valid
    && i_phase_word == PW_NO_ADJUST |=> $stable(r.integ))
    else $error("no-adjust phaseword moved the loop");
  holdover_a: assert property (r.mode == MODE_HOLD [*2]
    |=> $stable(r.integ) && o_holdover)
    else $error("holdover did not freeze deviation");
  src_leave_a: assert property (r.src != SRC_TS && r.mode != MODE_HOLD |=> !o_holdover)
    else $error("automatic holdover outlived stamp source");
  freerun_a: assert property (r.mode == MODE_FREE && r.rate == RATE_1544
    |=> r.acc == $past(r.acc) + INC_1544)
    else $error("freerun rate wrong");
  bresp_hold_a: assert property (r.bvalid && !i_bready |=> r.bvalid && $stable(r.bresp))
    else $error("write response dropped early");
endmodule : sacr_top
`default_nettype wire

// ===== tb/sacr_engine_model.sv
// reassembly engine model: feeds stamps and fill phasewords to one port
`timescale 1ns/10ps
`default_nettype none
module sacr_engine_model import sacr_pkg::*; (
  input wire logic i_clk,
  output logic o_ts_valid,
  output logic [TS_W-1:0] o_ts_data,
  output logic o_phase_valid,
  output logic [PW_W-1:0] o_phase_word
);
  initial begin
    o_ts_valid = 1'b0;
    o_ts_data = 5'h00;
    o_phase_valid = 1'b0;
    o_phase_word = 8'h00;
  end
  // ****************************************************************
  // transfers
  // ****************************************************************
  // bit 4 carries the lost-cell flag above the nibble
  task automatic send_ts(input logic [NIB_W-1:0] nib, input logic err);
    @(posedge i_clk);
    o_ts_valid <= 1'b1;
    o_ts_data <= {err, nib};
    @(posedge i_clk);
    o_ts_valid <= 1'b0;
    // stale data would hide a late sample
    o_ts_data <= ~{err, nib};
  endtask : send_ts
  task automatic send_pw(input logic [PW_W-1:0] pw);
    @(posedge i_clk);
    o_phase_valid <= 1'b1;
    o_phase_word <= pw;
    @(posedge i_clk);
    o_phase_valid <= 1'b0;
    o_phase_word <= ~pw;
  endtask : send_pw
endmodule : sacr_engine_model
`default_nettype wire

// ===== tb/sacr_top_tb_top.sv
// self-checking bench for the clock recovery front end
`timescale 1ns/10ps
`default_nettype none
module sacr_top_tb_top import sacr_pkg::*; ();
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ts_valid, ph_valid, rclk, hold, irq;
  logic [TS_W-1:0] ts_data;
  logic [PW_W-1:0] ph_word;
  logic lts_valid = 1'b0;
  logic [NIB_W-1:0] lts = 4'h0;
  logic line_clk = 1'b0;
  logic net_clk = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00;
  logic [ADDR_W-1:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int errors = 0;
  int samples_checked = 0;
  int ncyc = 0;

  initial begin
    forever #2 clk = ~clk;
  end
  // slow pins only keep the synchronisers busy
  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    if (ncyc % 61 == 0) line_clk <= ~line_clk;
    if (ncyc % 15625 == 0) net_clk <= ~net_clk;
  end

  sacr_engine_model eng (.i_clk(clk), .o_ts_valid(ts_valid), .o_ts_data(ts_data),
    .o_phase_valid(ph_valid), .o_phase_word(ph_word));
  sacr_top dut (.i_clk(clk), .i_srst(srst), .i_ts_valid(ts_valid), .i_ts_data(ts_data),
    .i_local_ts_valid(lts_valid), .i_local_ts(lts), .i_phase_valid(ph_valid),
    .i_phase_word(ph_word), .i_line_clk(line_clk), .i_net_clk(net_clk),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .o_recovered_port_clock(rclk), .o_holdover(hold), .o_irq(irq));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr
  // local stamp pulse doubles as the fifo read request
  task automatic pull(input logic [NIB_W-1:0] n);
    @(posedge clk);
    lts_valid <= 1'b1;
    lts <= n;
    @(posedge clk);
    lts_valid <= 1'b0;
    lts <= ~n;
    repeat (2) @(posedge clk);
  endtask : pull

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("irq", 32'(irq), 32'h0);
    axr(A_CTRL);
    chk("ctrl", rd, 32'(RATE_RST));
    axr(A_AVG);
    chk("avg", rd, 32'(AVG_RST));
    axr(8'h40);
    chk("rresp", 32'(rs), 32'(RESP_SLVERR));
    axw(8'h40, 32'h1);
    chk("bresp", 32'(rs), 32'(RESP_SLVERR));
    $display("test reset done");
  endtask : t_reset
  task automatic t_fifo;
    logic [31:0] f0;
    logic [15:0] e;
    axw(A_CTRL, 32'h5);
    for (int i = 0; i < FDEPTH; i++) eng.send_ts(4'(i + 1), 1'b0);
    axr(A_STATUS);
    chk("no ovf", 32'(rd[ST_OVF]), 32'h0);
    eng.send_ts(4'h9, 1'b0);
    axr(A_STATUS);
    chk("ovf", 32'(rd[ST_OVF]), 32'h1);
    axr(A_FILTER);
    f0 = rd;
    // every stamp runs one ahead of its local partner
    for (int i = 0; i < FDEPTH; i++) pull(4'(i));
    axr(A_FILTER);
    e = f0[15:0] + 16'(FDEPTH);
    chk("ts step", 32'(rd[15:0]), 32'(e));
    chk("hold", 32'(hold), 32'h0);
    axr(A_STATUS);
    chk("no udr", 32'(rd[ST_UDR]), 32'h0);
    pull(4'h0);
    axr(A_STATUS);
    chk("udr", 32'(rd[ST_UDR]), 32'h1);
    chk("auto hold", 32'(hold), 32'h1);
    eng.send_ts(4'h1, 1'b0);
    eng.send_ts(4'h2, 1'b0);
    pull(4'h2);
    chk("hold exit", 32'(hold), 32'h0);
    axr(A_FILTER);
    f0 = rd;
    eng.send_ts(4'h3, 1'b1);
    // if the flagged stamp were used the loop would step by two
    pull(4'h1);
    axr(A_STATUS);
    chk("flag", 32'(rd[ST_ERR]), 32'h1);
    axr(A_FILTER);
    chk("loop kept", 32'(rd[15:0]), 32'(f0[15:0]));
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_irq;
    axw(A_STATUS, 32'hf);
    axr(A_STATUS);
    chk("w1c", rd, 32'h0);
    // slot left behind by the earlier drain is stale now
    pull(4'h0);
    axr(A_STATUS);
    chk("udr again", 32'(rd[ST_UDR]), 32'h1);
    chk("masked", 32'(irq), 32'h0);
    axw(A_MASK, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq up", 32'(irq), 32'h1);
    axw(A_STATUS, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq down", 32'(irq), 32'h0);
    $display("test irq done");
  endtask : t_irq
  task automatic t_adapt;
    logic [PW_W-1:0] pw [5] = '{8'h90, 8'h70, PW_NO_ADJUST, PW_SLIP_UNDER, PW_SLIP_OVER};
    logic [15:0] dl [5] = '{16'h0010, 16'hfff0, 16'h0000, -SLIP_STEP, SLIP_STEP};
    logic [15:0] base;
    axw(A_CTRL, 32'h0d);
    axr(A_FILTER);
    base = rd[15:0];
    for (int i = 0; i < 5; i++) begin
      eng.send_pw(pw[i]);
      axr(A_FILTER);
      base = base + dl[i];
      chk("integ", 32'(rd[15:0]), 32'(base));
    end
    axr(A_STATUS);
    chk("slip", 32'(rd[ST_SLIP]), 32'h1);
    axw(A_CTRL, 32'h1d);
    repeat (3) @(posedge clk);
    chk("hold mode", 32'(hold), 32'h1);
    eng.send_pw(8'h90);
    axr(A_FILTER);
    chk("hold integ", 32'(rd[15:0]), 32'(base));
    axw(A_CPU_OFS, 32'h1234);
    axr(A_CPU_OFS);
    chk("cpu ofs", rd, 32'h1234);
    axw(A_CTRL, 32'h3d);
    eng.send_pw(8'h90);
    axr(A_FILTER);
    chk("cpu integ", 32'(rd[15:0]), 32'(base));
    chk("cpu no hold", 32'(hold), 32'h0);
    $display("test adaptive done");
  endtask : t_adapt
  task automatic t_rate;
    int lo [3] = '{25, 33, 67};
    int n;
    logic p;
    // edge count over 4096 cycles, lo or one more for phase
    for (int r = 0; r < 3; r++) begin
      // network source selected: freerun must ignore its detector
      axw(A_CTRL, 32'h28 | 32'(r));
      repeat (64) @(posedge clk);
      n = 0;
      p = rclk;
      repeat (4096) begin
        @(posedge clk);
        if (rclk && !p) n++;
        p = rclk;
      end
      chk("rate", 32'(n >= lo[r] && n <= lo[r] + 1), 32'h1);
    end
    $display("test rate done");
  endtask : t_rate

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_fifo;
    t_irq;
    t_adapt;
    t_rate;
    stop_test;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    stop_test;
  end
endmodule : sacr_top_tb_top
`default_nettype wire
